/* hw/hwic_pkg.sv */
// How it works
// R1: Each 6-bit rate code selects a fixed SCL divider and SDA hold count in bus clocks.
// R2: The control register is read and written at any time and resets to zero.
// R3: While module enable is low the serial side is held in reset, yet registers stay reachable.
// R4: No other control bit has any effect until module enable is already set.
// R5: A slave enabled mid-byte ignores that byte and wakes only on the next start condition.
// R6: A master enabled mid-transfer cannot see the bus busy and may lose arbitration once.
// R7: Software should set the shared port data bits 6 and 7 before clearing module enable.
// R8: A low interrupt enable blocks the request but leaves any pending flag set.
// R9: A high interrupt enable raises the request whenever the pending flag is set; the code also needs the flag's bit set in the mask register.
// R10: The SCL period is twice the sum of first-tap delay, taps times tap spacing, and two; the code uses SCL tap minus one times tap spacing.
// R11: Master select rising makes a START, falling makes a STOP, arbitration loss clears it silently.
// R12: Software clears the pending flag by writing a one to it.
// R13: Writing one to repeat start makes a repeated START when master, and it reads as zero.
// R14: The divider and hold counters run only while enabled and restart on leaving reset.
package hwic_pkg;
  localparam logic [9:0] IDX_RATE     = 10'h0E1;
  localparam logic [9:0] IDX_CTRL     = 10'h0E2;
  localparam logic [9:0] IDX_STAT     = 10'h0E3;
  localparam logic [9:0] IDX_MASK     = 10'h0E4;
  localparam int         CTRL_EN      = 7;
  localparam int         CTRL_IE      = 6;
  localparam int         CTRL_MS      = 5;
  localparam int         CTRL_RPT     = 2;
  localparam int         CTRL_HALT    = 0;
  localparam int         STAT_BUSY    = 5;
  localparam int         STAT_ARB     = 4;
  localparam int         STAT_PEND    = 1;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] CTRL_WMASK   = 8'hF9;
  localparam logic [7:0] STAT_RST     = 8'h00;
  localparam logic [7:0] STAT_W1C     = 8'h12;
  localparam logic [7:0] MASK_RST     = 8'h12;
  localparam logic [5:0] RATE_RST     = 6'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // First-tap delay per prescale code, SCL tap minus one and SDA tap minus one per tap code.
  localparam logic [7:0][6:0] SCL2TAP = {7'h7E, 7'h3E, 7'h1E, 7'h0E, 7'h06, 7'h06, 7'h04, 7'h04};
  localparam logic [7:0][3:0] SCL_TM1 = {4'hE, 4'hB, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4};
  localparam logic [7:0][1:0] SDA_TM1 = {2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
  localparam logic [11:0] DIV_OFS     = 12'h002;
  localparam logic [11:0] HOLD_OFS    = 12'h003;

  typedef enum logic [6:0] {
    HWIC_IDLE    = 7'h01,
    HWIC_ST_SDA  = 7'h02,
    HWIC_OWN     = 7'h04,
    HWIC_SP_HOLD = 7'h08,
    HWIC_SP_SCL  = 7'h10,
    HWIC_RS_HOLD = 7'h20,
    HWIC_RS_SCL  = 7'h40
  } hwic_mstate_t;
endpackage

/* hw/hwic_line_if.sv */
`timescale 1ns/1ns
// Filtered bus line levels and start/stop events, one cycle pulses.
interface hwic_line_if;
  logic scl_lvl;
  logic sda_lvl;
  logic start_det;
  logic stop_det;
  modport src (output scl_lvl, output sda_lvl, output start_det, output stop_det);
  modport dst (input scl_lvl, input sda_lvl, input start_det, input stop_det);
endinterface

/* hw/hwic_pin_sync.sv */
`timescale 1ns/1ns
module hwic_pin_sync (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  hwic_line_if.src    line
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
    logic       start;
    logic       stop;
  } hwic_sync_t;

  hwic_sync_t r;
  hwic_sync_t n;
  logic [1:0] pin;

  assign pin = {scl_i, sda_i};

  // Bit 1 is SCL, bit 0 is SDA; a level is taken only once stages two and three agree.
  always_comb begin
    n = r;
    n.s1 = pin;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 2; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.lvl[i] = r.s3[i];
      end
    end
    n.start = r.lvl[1] && n.lvl[1] && r.lvl[0] && !n.lvl[0];
    n.stop  = r.lvl[1] && n.lvl[1] && !r.lvl[0] && n.lvl[0];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, lvl: 2'h3, start: 1'b0, stop: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign line.scl_lvl   = r.lvl[1];
  assign line.sda_lvl   = r.lvl[0];
  assign line.start_det = r.start;
  assign line.stop_det  = r.stop;
endmodule

/* hw/hwic_rate_dec.sv */
`timescale 1ns/1ns
module hwic_rate_dec (
  input  wire logic [5:0]  rate_code,
  output logic      [11:0] scl_div,
  output logic      [9:0]  sda_hold
);
  logic [2:0]  hi;
  logic [2:0]  lo;
  logic [11:0] first;
  logic [11:0] hold_w;

  always_comb begin
    hi     = rate_code[5:3];
    lo     = rate_code[2:0];
    first  = {5'h00, hwic_pkg::SCL2TAP[hi]};
    // R10: divider equation
    scl_div = (first + ({8'h00, hwic_pkg::SCL_TM1[lo]} << hi) + hwic_pkg::DIV_OFS) << 1;
    // R1: hold equation
    hold_w   = first + ({10'h000, hwic_pkg::SDA_TM1[lo]} << hi) + hwic_pkg::HOLD_OFS;
    sda_hold = hold_w[9:0];
  end
endmodule

/* hw/hwic_bus_ctrl.sv */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
module hwic_bus_ctrl (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        cpu_wait,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);
  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic [9:0]             aw_idx;
    logic [7:0]             wdat;
    logic                   wstb;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic [7:0]             ctrl;
    logic [5:0]             rate;
    logic [7:0]             stat;
    logic [7:0]             mask;
    logic                   busy;
    hwic_pkg::hwic_mstate_t st;
    logic [11:0]            tmr;
    logic                   scl_oe;
    logic                   sda_oe;
    logic                   drv_lvl;
    logic                   irq;
  } hwic_ctrl_t;

  localparam hwic_ctrl_t RST_VAL = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1,
    ctrl: hwic_pkg::CTRL_RST, stat: hwic_pkg::STAT_RST, mask: hwic_pkg::MASK_RST,
    rate: hwic_pkg::RATE_RST, st: hwic_pkg::HWIC_IDLE, default: '0};

  hwic_ctrl_t  r;
  hwic_ctrl_t  n;
  hwic_line_if line ();
  logic [11:0] scl_div;
  logic [9:0]  sda_hold;
  logic [11:0] half_ld;
  logic [11:0] hold_ld;
  logic        en;
  logic        halt;
  logic        tick;
  logic        do_wr;
  logic        wr_ok;
  logic        wr_ctrl;
  logic        ms_old;
  logic        ms_new;
  logic        arb;
  logic        own_evt;
  logic [7:0]  stat_rd;
  logic        rd_map;
  logic [7:0]  rd_val;

  hwic_pin_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .line    (line.src)
  );

  hwic_rate_dec u_rate (
    .rate_code (r.rate),
    .scl_div   (scl_div),
    .sda_hold  (sda_hold)
  );

  assign half_ld = {1'b0, scl_div[11:1]} - 12'h001;
  assign hold_ld = {2'h0, sda_hold};
  assign en      = r.ctrl[hwic_pkg::CTRL_EN];
  assign halt    = r.ctrl[hwic_pkg::CTRL_HALT] && cpu_wait;
  assign tick    = (r.tmr == 12'h000) && !halt;
  assign stat_rd = r.stat | ({7'h00, r.busy} << hwic_pkg::STAT_BUSY);

  always_comb begin
    n       = r;
    arb     = 1'b0;
    own_evt = 1'b0;
    ms_old  = r.ctrl[hwic_pkg::CTRL_MS];
    ms_new  = r.wdat[hwic_pkg::CTRL_MS];

    // Address and data are taken independently; the write lands once both are held.
    if (r.awready && awvalid) begin
      n.awready = 1'b0;
      n.aw_idx  = awaddr[11:2];
    end
    if (r.wready && wvalid) begin
      n.wready = 1'b0;
      n.wdat   = wdata[7:0];
      n.wstb   = wstrb[0];
    end
    do_wr   = !r.awready && !r.wready && !r.bvalid;
    wr_ok   = r.aw_idx inside {hwic_pkg::IDX_RATE, hwic_pkg::IDX_CTRL,
                               hwic_pkg::IDX_STAT, hwic_pkg::IDX_MASK};
    wr_ctrl = do_wr && r.wstb && (r.aw_idx == hwic_pkg::IDX_CTRL);
    if (do_wr) begin
      n.bvalid = 1'b1;
      n.bresp  = wr_ok ? hwic_pkg::RESP_OKAY : hwic_pkg::RESP_SLVERR;
    end
    if (r.bvalid && bready) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    rd_map = 1'b1;
    case (araddr[11:2])
      hwic_pkg::IDX_RATE: rd_val = {2'h0, r.rate};
      // R13: repeat start reads zero
      hwic_pkg::IDX_CTRL: rd_val = r.ctrl;
      hwic_pkg::IDX_STAT: rd_val = stat_rd;
      hwic_pkg::IDX_MASK: rd_val = r.mask;
      default: begin
        rd_val = 8'h00;
        rd_map = 1'b0;
      end
    endcase
    if (r.arready && arvalid) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rdata   = {24'h000000, rd_val};
      n.rresp   = rd_map ? hwic_pkg::RESP_OKAY : hwic_pkg::RESP_SLVERR;
    end
    if (r.rvalid && rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // R2: control storage
    if (wr_ctrl) begin
      n.ctrl = r.wdat & hwic_pkg::CTRL_WMASK;
    end
    if (do_wr && r.wstb && (r.aw_idx == hwic_pkg::IDX_RATE)) begin
      n.rate = r.wdat[5:0];
    end
    if (do_wr && r.wstb && (r.aw_idx == hwic_pkg::IDX_MASK)) begin
      n.mask = r.wdat;
    end

    // R14: counters tick
    if (r.tmr != 12'h000 && !halt) begin
      n.tmr = r.tmr - 12'h001;
    end

    // SCL release waits for the line to rise, so a stretching slave extends the phase.
    case (r.st)
      hwic_pkg::HWIC_ST_SDA: begin
        if (tick) begin
          n.st    = hwic_pkg::HWIC_OWN;
          own_evt = 1'b1;
        end
      end
      hwic_pkg::HWIC_SP_HOLD: begin
        if (tick) begin
          n.st  = hwic_pkg::HWIC_SP_SCL;
          n.tmr = half_ld;
        end
      end
      hwic_pkg::HWIC_SP_SCL: begin
        if (!line.scl_lvl) begin
          n.tmr = half_ld;
        end else if (tick) begin
          n.st = hwic_pkg::HWIC_IDLE;
        end
      end
      hwic_pkg::HWIC_RS_HOLD: begin
        if (tick) begin
          n.st  = hwic_pkg::HWIC_RS_SCL;
          n.tmr = half_ld;
        end
      end
      hwic_pkg::HWIC_RS_SCL: begin
        if (!line.scl_lvl) begin
          n.tmr = half_ld;
        end else if (tick) begin
          n.st  = hwic_pkg::HWIC_ST_SDA;
          n.tmr = half_ld;
        end
      end
      hwic_pkg::HWIC_IDLE, hwic_pkg::HWIC_OWN: begin
        n.st = r.st;
      end
      default: begin
        n.st = hwic_pkg::HWIC_IDLE;
      end
    endcase

    // R4: effects need prior enable
    if (wr_ctrl && en) begin
      if (!ms_old && ms_new) begin
        // R6: busy is known only from starts seen since enable
        if (r.st == hwic_pkg::HWIC_IDLE && !r.busy) begin
          // R11: start on rise
          n.st  = hwic_pkg::HWIC_ST_SDA;
          n.tmr = half_ld;
        end else begin
          arb = 1'b1;
        end
      end else if (ms_old && !ms_new && r.st == hwic_pkg::HWIC_OWN) begin
        // R11: stop on fall
        n.st  = hwic_pkg::HWIC_SP_HOLD;
        n.tmr = hold_ld;
      end else if (r.wdat[hwic_pkg::CTRL_RPT]) begin
        // R13: repeated start
        if (!ms_old) begin
          arb = 1'b1;
        end else if (ms_new && r.st == hwic_pkg::HWIC_OWN) begin
          n.st  = hwic_pkg::HWIC_RS_HOLD;
          n.tmr = hold_ld;
        end
      end
    end
    if (line.stop_det && r.st == hwic_pkg::HWIC_OWN) begin
      arb = 1'b1;
    end
    // R11: silent clear on loss
    if (arb) begin
      n.ctrl[hwic_pkg::CTRL_MS] = 1'b0;
      n.st                      = hwic_pkg::HWIC_IDLE;
    end

    // R5: busy is learnt only from a start seen after enable
    if (line.start_det) begin
      n.busy = 1'b1;
    end else if (line.stop_det) begin
      n.busy = 1'b0;
    end

    // R12: clear by writing one; a same-cycle event still sets
    if (do_wr && r.wstb && (r.aw_idx == hwic_pkg::IDX_STAT)) begin
      n.stat = r.stat & ~(r.wdat & hwic_pkg::STAT_W1C);
    end
    if (arb) begin
      n.stat[hwic_pkg::STAT_ARB]  = 1'b1;
      n.stat[hwic_pkg::STAT_PEND] = 1'b1;
    end
    if (own_evt) begin
      n.stat[hwic_pkg::STAT_PEND] = 1'b1;
    end

    // R3: serial side held in reset
    if (!en) begin
      n.st   = hwic_pkg::HWIC_IDLE;
      n.tmr  = 12'h000;
      n.busy = 1'b0;
      n.stat = hwic_pkg::STAT_RST;
    end

    n.scl_oe  = n.st inside {hwic_pkg::HWIC_OWN, hwic_pkg::HWIC_SP_HOLD, hwic_pkg::HWIC_RS_HOLD};
    n.sda_oe  = n.st inside {hwic_pkg::HWIC_ST_SDA, hwic_pkg::HWIC_OWN,
                             hwic_pkg::HWIC_SP_HOLD, hwic_pkg::HWIC_SP_SCL};
    n.drv_lvl = 1'b0;
    // R8: gate without clearing
    // R9: request follows flag
    n.irq = n.ctrl[hwic_pkg::CTRL_EN] && n.ctrl[hwic_pkg::CTRL_IE] && |(n.stat & n.mask);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  assign awready = r.awready;
  assign wready  = r.wready;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign arready = r.arready;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;
  assign scl_oe  = r.scl_oe;
  assign sda_oe  = r.sda_oe;
  assign scl_o   = r.drv_lvl;
  assign sda_o   = r.drv_lvl;
  assign irq     = r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ctrl_read;
    arvalid && arready && (araddr[11:2] == hwic_pkg::IDX_CTRL);
  endsequence
  sequence s_start_go;
    wr_ctrl && en && !ms_old && ms_new && r.st == hwic_pkg::HWIC_IDLE && !r.busy;
  endsequence

  property p_rate_top;
    r.rate == 6'h3F |-> scl_div == 12'hF00 && sda_hold == 10'h201;
  endproperty
  a_rate_top: assert property (p_rate_top) else $error("rate 3F decode wrong"); // R1
  property p_rate_mid;
    r.rate == 6'h20 |-> scl_div == 12'h0A0 && sda_hold == 10'h011;
  endproperty
  a_rate_mid: assert property (p_rate_mid) else $error("rate 20 decode wrong"); // R10
  property p_rpt_zero;
    s_ctrl_read |=> rvalid && !rdata[hwic_pkg::CTRL_RPT];
  endproperty
  a_rpt_zero: assert property (p_rpt_zero) else $error("repeat start read back"); // R13
  property p_off_quiet;
    !en |=> !scl_oe && !sda_oe && !r.busy;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled block drives bus"); // R3
  property p_irq_block;
    !r.ctrl[hwic_pkg::CTRL_IE] |-> !irq;
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("irq while disabled"); // R8
  property p_flag_kept;
    en && r.stat[hwic_pkg::STAT_PEND] && !do_wr ##1 en |-> r.stat[hwic_pkg::STAT_PEND];
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("pending flag lost"); // R8
  property p_irq_raise;
    en && r.ctrl[hwic_pkg::CTRL_IE] && |(r.stat & r.mask) |-> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq missing"); // R9
  property p_start;
    s_start_go |=> sda_oe && !scl_oe ##1 sda_oe;
  endproperty
  a_start: assert property (p_start) else $error("start not driven"); // R11
  property p_arb_clear;
    arb |=> !r.ctrl[hwic_pkg::CTRL_MS] && r.st == hwic_pkg::HWIC_IDLE && r.stat[hwic_pkg::STAT_ARB];
  endproperty
  a_arb_clear: assert property (p_arb_clear) else $error("loss not handled"); // R11
  property p_tmr_rest;
    !en |=> r.tmr == 12'h000;
  endproperty
  a_tmr_rest: assert property (p_tmr_rest) else $error("counter runs while off"); // R14
  property p_no_early_busy;
    $rose(en) |-> !r.busy;
  endproperty
  a_no_early_busy: assert property (p_no_early_busy) else $error("busy before start"); // R5
endmodule

/* testbench/hwic_bus_peer.sv */
`timescale 1ns/1ns
// Another party on the two bus lines, with the pull-ups that both lines carry.
module hwic_bus_peer (
  input  wire logic clk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl_i,
  output logic      sda_i
);
  logic scl_low;
  logic sda_low;

  // Released lines float up through the pull-ups, so a wired AND is exact.
  // released lines high
  assign scl_i = !(scl_oe || scl_low);
  assign sda_i = !(sda_oe || sda_low);

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic hold_cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic start_cond();
    sda_low <= 1'b1;
    hold_cycles(20);
    scl_low <= 1'b1;
    hold_cycles(20);
  endtask

  task automatic stop_cond();
    sda_low <= 1'b1;
    scl_low <= 1'b0;
    hold_cycles(20);
    sda_low <= 1'b0;
    hold_cycles(20);
  endtask
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
  localparam logic [11:0] A_RATE = {hwic_pkg::IDX_RATE, 2'b00};
  localparam logic [11:0] A_CTRL = {hwic_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_STAT = {hwic_pkg::IDX_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {hwic_pkg::IDX_MASK, 2'b00};
  logic        clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, cpu_wait;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire  logic  awready, wready, bvalid, arready, rvalid, irq;
  wire  logic  scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  int          n_mismatch, n_tests, c;
  logic [7:0]  rv;
  logic [1:0]  rsp;

  hwic_bus_ctrl i_hwic_bus_ctrl (.clk(clk), .sys_rst(sys_rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cpu_wait(cpu_wait), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  hwic_bus_peer i_hwic_bus_peer (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .scl_i(scl_i), .sda_i(sda_i));

  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n > 5000) begin
      n_mismatch++;
      $display("Error wait expected done seen timeout");
      summarize();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
      tmo(n);
    end while (!bvalid);
    rsp = bresp;
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
      tmo(n);
    end while (!rvalid);
    rv = rdata[7:0];
    rsp = rresp;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] ex);
    rd(a);
    `CHK("register", ex, rv)
  endtask

  task automatic wait_oe(input bit on_scl, input logic lvl);
    c = 0;
    while ((on_scl ? scl_oe : sda_oe) !== lvl) begin
      @(posedge clk);
      c++;
      tmo(c);
    end
  endtask

  task automatic do_start(input int dv);
    wr(A_CTRL, 8'hA0);
    wait_oe(0, 1'b1);
    wait_oe(1, 1'b1);
    `CHK("start_scl_delay", 1'b1, c >= dv / 2 - 2 && c <= dv / 2 + 6)
    `CHK("line_lvl", 2'b00, {scl_o, sda_o})
  endtask

  task automatic do_stop(input int dv, input int hd);
    wr(A_CTRL, 8'h80);
    wait_oe(1, 1'b0);
    `CHK("stop_hold", 1'b1, c >= hd - 3 && c <= hd + 4)
    wait_oe(0, 1'b0);
    `CHK("stop_sda_delay", 1'b1, c >= dv / 2 - 2 && c <= dv / 2 + 8)
    repeat (10) @(posedge clk);
    rd_chk(A_STAT, 8'h00);
  endtask

  task automatic t_regs();
    rd_chk(A_CTRL, 8'h00);
    rd_chk(A_RATE, 8'h00);
    rd_chk(A_STAT, 8'h00);
    rd_chk(A_MASK, 8'h12);
    `CHK("read_okay", hwic_pkg::RESP_OKAY, rsp)
    rd_chk(12'h3FC, 8'h00);
    `CHK("read_resp", hwic_pkg::RESP_SLVERR, rsp)
    wr(12'h3FC, 8'hFF);
    `CHK("write_resp", hwic_pkg::RESP_SLVERR, rsp)
  endtask

  task automatic t_ctrl();
    wr(A_CTRL, 8'h7F);
    repeat (40) @(posedge clk);
    rd_chk(A_CTRL, 8'h79);
    `CHK("idle_oe", 2'b00, {scl_oe, sda_oe})
    rd_chk(A_STAT, 8'h00);
    wr(A_CTRL, 8'h00);
    rd_chk(A_CTRL, 8'h00);
  endtask

  // Rate codes with their divider and hold counts, master start and stop for each.
  task automatic t_master();
    logic [5:0] cd [4] = '{6'h1B, 6'h20, 6'h2E, 6'h3F};
    int         dv [4] = '{128, 160, 768, 3840};
    int         hd [4] = '{17, 17, 129, 513};
    wr(A_CTRL, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(A_RATE, {2'b00, cd[i]});
      do_start(dv[i]);
      rd_chk(A_STAT, 8'h22);
      `CHK("irq_blocked", 1'b0, irq)
      wr(A_CTRL, 8'hE0);
      repeat (2) @(posedge clk);
      `CHK("irq_raised", 1'b1, irq)
      wr(A_MASK, 8'h00);
      repeat (2) @(posedge clk);
      `CHK("irq_masked", 1'b0, irq)
      wr(A_MASK, 8'h12);
      wr(A_CTRL, 8'hA0);
      repeat (2) @(posedge clk);
      `CHK("irq_off", 1'b0, irq)
      rd_chk(A_STAT, 8'h22);
      wr(A_STAT, 8'h02);
      rd_chk(A_STAT, 8'h20);
      do_stop(dv[i], hd[i]);
    end
  endtask

  task automatic t_mid();
    wr(A_CTRL, 8'h00);
    i_hwic_bus_peer.start_cond();
    wr(A_CTRL, 8'h80);
    rd_chk(A_STAT, 8'h00);
    // The start seen while off is unknown, so a start request drives blindly.
    wr(A_CTRL, 8'hA0);
    `CHK("blind_start", 1'b1, sda_oe)
    wr(A_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("reset_oe", 2'b00, {scl_oe, sda_oe})
    i_hwic_bus_peer.stop_cond();
    wr(A_CTRL, 8'h80);
    i_hwic_bus_peer.start_cond();
    rd_chk(A_STAT, 8'h20);
    wr(A_CTRL, 8'hA0);
    repeat (10) @(posedge clk);
    rd_chk(A_STAT, 8'h32);
    rd_chk(A_CTRL, 8'h80);
    `CHK("lost_oe", 2'b00, {scl_oe, sda_oe})
    wr(A_STAT, 8'h12);
    wr(A_CTRL, 8'h84);
    repeat (4) @(posedge clk);
    rd_chk(A_STAT, 8'h32);
    wr(A_STAT, 8'h12);
    i_hwic_bus_peer.stop_cond();
    rd_chk(A_STAT, 8'h00);
  endtask

  task automatic t_dis();
    wr(A_RATE, 8'h1B);
    do_start(128);
    wr(A_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("dis_oe", 2'b00, {scl_oe, sda_oe})
    rd_chk(A_STAT, 8'h00);
    repeat (10) @(posedge clk);
    wr(A_CTRL, 8'h80);
    do_start(128);
    wr(A_STAT, 8'h02);
    wr(A_CTRL, 8'hA4);
    wait_oe(1, 1'b0);
    `CHK("rs_sda_free", 1'b0, sda_oe)
    `CHK("rs_hold", 1'b1, c >= 14 && c <= 21)
    wait_oe(1, 1'b1);
    rd_chk(A_STAT, 8'h22);
    rd_chk(A_CTRL, 8'hA0);
    wr(A_STAT, 8'h02);
    do_stop(128, 17);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, cpu_wait} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    n_mismatch = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_ctrl();
    t_master();
    t_mid();
    t_dis();
    summarize();
  end
endmodule
